// ===== verilog/sup_pkg.sv
package sup_pkg;

   // ---------------------------------------------------------------
   // Widths
   // ---------------------------------------------------------------
   localparam int CNT_W   = 16;
   localparam int PLAT_W  = 4;
   localparam int NUM_SUP = 4;
   localparam int ADDR_W  = 8;

   // ---------------------------------------------------------------
   // Modes and selections
   // ---------------------------------------------------------------
   typedef enum logic [1:0] {MODE_OTHER, MODE_CONFIG, MODE_ACTIVE}
      opmode_e;
   typedef enum logic [1:0] {SUP_SEC_UV, SUP_SEC_OV, SUP_THIRD_UV,
      SUP_THIRD_OV} supsel_e;

   // ---------------------------------------------------------------
   // Controller register map (byte addresses)
   // ---------------------------------------------------------------
   localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h00;
   localparam logic [ADDR_W-1:0] OFS_CMD  = 8'h04;
   localparam logic [ADDR_W-1:0] OFS_STAT = 8'h08;
   localparam logic [ADDR_W-1:0] OFS_PCNT = 8'h0C;
   localparam logic [ADDR_W-1:0] OFS_SCNT = 8'h10;

   // Control fields
   localparam int CTRL_OCP     = 0;
   localparam int CTRL_SUP     = 1;
   localparam int CTRL_SEL     = 2;
   localparam int CTRL_CLK     = 4;
   localparam int CTRL_DIO     = 5;
   localparam int CTRL_DIO_OUT = 6;
   localparam int CTRL_PLAT    = 8;
   localparam int CTRL_W       = 12;
   localparam logic [CTRL_W-1:0] CTRL_RESET = 12'h000;

   // Command and status fields
   localparam int CMD_PRIMARY_CLEAR_REQUEST   = 0;
   localparam int STAT_MODE  = 0;
   localparam int STAT_ERR   = 2;
   localparam int STAT_DIO   = 3;

   // AXI responses
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : sup_pkg

// ===== verilog/sup_link.sv
`timescale 1ns/1ps
interface sup_link (input wire logic clk);

   // ---------------------------------------------------------------
   // Controller to driver
   // ---------------------------------------------------------------
   logic                      pwm;
   logic                      ocpTest;
   logic                      supTest;
   sup_pkg::supsel_e          supSel;
   logic                      clkTest;
   logic                      dioTest;
   logic                      clrPrimary;

   // ---------------------------------------------------------------
   // Driver to controller
   // ---------------------------------------------------------------
   sup_pkg::opmode_e          mode;
   logic                      errNotify;
   logic [sup_pkg::CNT_W-1:0] priCount;
   logic [sup_pkg::CNT_W-1:0] secCount;
   logic                      dioOut;
   logic                      dioOe;
   logic                      dioLevel;

   // Undriven pin settles low
   assign dioLevel = dioOe ? dioOut : 1'b0;

   modport dev_mp (
      input  clk, pwm, ocpTest, supTest, supSel, clkTest, dioTest,
             clrPrimary,
      output mode, errNotify, priCount, secCount, dioOut, dioOe
   );

   modport host_mp (
      input  clk, mode, errNotify, priCount, secCount, dioLevel,
      output pwm, ocpTest, supTest, supSel, clkTest, dioTest,
             clrPrimary
   );

endinterface : sup_link

// ===== verilog/gate_sup_dev.sv
`timescale 1ns/1ps
module gate_sup_dev (
   // Link to controller
   sup_link.dev_mp                  lnk,
   // Reset
   input  wire logic                srst,
   // Device state
   input  wire sup_pkg::opmode_e    opMode,
   // Comparator forcing
   output logic [1:0]               ocForce,
   output logic [sup_pkg::NUM_SUP-1:0] supForce,
   // Error reaction
   output logic                     ocError,
   // Signal paths
   output logic                     gateDrive,
   output logic                     secPwm
);

   // ---------------------------------------------------------------
   // Mode and edge tracking
   // ---------------------------------------------------------------
   logic                       pwmPrev_q;
   sup_pkg::opmode_e           modePrev_q;
   logic                       pwmRise;
   logic                       pwmFall;
   logic                       inConfig;
   logic                       inActive;
   logic                       modeOk;
   logic                       enterActive;
   logic                       ocError_q;
   logic [1:0]                 ocForce_q;
   logic [sup_pkg::NUM_SUP-1:0] supForce_q;
   logic                       err_q;
   logic                       gate_q;
   logic                       sec_q;
   logic                       dioOut_q;
   logic                       dioOe_q;

   assign pwmRise     = lnk.pwm & ~pwmPrev_q;
   assign pwmFall     = ~lnk.pwm & pwmPrev_q;
   assign inConfig    = (opMode == sup_pkg::MODE_CONFIG);
   assign inActive    = (opMode == sup_pkg::MODE_ACTIVE);
   assign modeOk      = inConfig | inActive;
   assign enterActive = inActive & (modePrev_q != sup_pkg::MODE_ACTIVE);

   always_ff @(posedge lnk.clk)
   begin
      if (srst)
      begin
         pwmPrev_q  <= 1'b0;
         modePrev_q <= sup_pkg::MODE_OTHER;
      end
      else
      begin
         pwmPrev_q  <= lnk.pwm;
         modePrev_q <= opMode;
      end
   end

   always_ff @(posedge lnk.clk)
   begin
      if (srst)
      begin
         lnk.mode <= sup_pkg::MODE_OTHER;
      end
      else
      begin
         lnk.mode <= opMode;
      end
   end

   // ---------------------------------------------------------------
   // Overcurrent test
   // ---------------------------------------------------------------
   always_ff @(posedge lnk.clk)
   begin
      if (srst)
      begin
         ocForce_q <= 2'h0;
      end
      else
      begin
         ocForce_q <= {2{lnk.ocpTest}};
      end
   end

   // One pulse per entry, so a long active phase reports once
   always_ff @(posedge lnk.clk)
   begin
      if (srst)
      begin
         ocError_q <= 1'b0;
      end
      else
      begin
         ocError_q <= lnk.ocpTest & enterActive;
      end
   end

   // ---------------------------------------------------------------
   // Supply monitor test
   // ---------------------------------------------------------------
   // Only the four secondary-side monitors exist in the select
   // encoding; the primary undervoltage monitor cannot be forced
   always_ff @(posedge lnk.clk)
   begin
      if (srst)
      begin
         supForce_q <= 4'h0;
      end
      else if (lnk.supTest)
      begin
         supForce_q <= 4'h1 << lnk.supSel;
      end
      else
      begin
         supForce_q <= 4'h0;
      end
   end

   // Notification to the controller; a new error wins over the drop
   always_ff @(posedge lnk.clk)
   begin
      if (srst)
      begin
         err_q <= 1'b0;
      end
      else if (ocError_q | (|supForce_q))
      begin
         err_q <= 1'b1;
      end
      else if (!lnk.ocpTest && !lnk.supTest)
      begin
         err_q <= 1'b0;
      end
   end

   // ---------------------------------------------------------------
   // Signal paths
   // ---------------------------------------------------------------
   // A pending error keeps the gate off, as a real fault would
   always_ff @(posedge lnk.clk)
   begin
      if (srst)
      begin
         gate_q <= 1'b0;
      end
      else
      begin
         gate_q <= lnk.pwm & inActive & ~err_q & ~lnk.dioTest
                   & ~lnk.ocpTest & ~lnk.clkTest;
      end
   end

   always_ff @(posedge lnk.clk)
   begin
      if (srst)
      begin
         sec_q <= 1'b0;
      end
      else
      begin
         sec_q <= lnk.pwm & ~lnk.dioTest;
      end
   end

   // Pin driven only while looping back, so a short shows up on it
   always_ff @(posedge lnk.clk)
   begin
      if (srst)
      begin
         dioOut_q <= 1'b0;
         dioOe_q  <= 1'b0;
      end
      else
      begin
         dioOe_q  <= lnk.dioTest & modeOk;
         dioOut_q <= lnk.dioTest & modeOk & lnk.pwm;
      end
   end

   // ---------------------------------------------------------------
   // Pulse counters: index 0 primary, index 1 secondary
   // ---------------------------------------------------------------
   // Both run on the one system clock; a second oscillator would
   // need its own domain and a crossing for the result
   for (genvar i = 0; i < 2; i++)
   begin : gCnt
      localparam logic [sup_pkg::CNT_W-1:0] MAXV = '1;
      logic                      en;
      logic [sup_pkg::CNT_W-1:0] cnt_q;
      logic [sup_pkg::CNT_W-1:0] res_q;

      assign en = (i == 0) ? modeOk : inActive;

      always_ff @(posedge lnk.clk)
      begin
         if (srst)
         begin
            cnt_q <= '0;
         end
         else if (pwmRise)
         begin
            cnt_q <= {{(sup_pkg::CNT_W-1){1'b0}}, en};
         end
         else if (lnk.pwm && en && cnt_q != MAXV)
         begin
            cnt_q <= cnt_q + 1'b1;
         end
      end

      // Capture beats a clear landing in the same cycle; a pulse seen
      // while the function is off leaves the last result standing
      always_ff @(posedge lnk.clk)
      begin
         if (srst)
         begin
            res_q <= '0;
         end
         else if (pwmFall && en)
         begin
            res_q <= cnt_q;
         end
         else if (i == 0 && lnk.clrPrimary)
         begin
            res_q <= '0;
         end
      end
   end

   // ---------------------------------------------------------------
   // Outputs
   // ---------------------------------------------------------------
   assign lnk.priCount  = gCnt[0].res_q;
   assign lnk.secCount  = gCnt[1].res_q;
   assign lnk.errNotify = err_q;
   assign lnk.dioOut    = dioOut_q;
   assign lnk.dioOe     = dioOe_q;
   assign ocForce       = ocForce_q;
   assign supForce      = supForce_q;
   assign ocError       = ocError_q;
   assign gateDrive     = gate_q;
   assign secPwm        = sec_q;

endmodule : gate_sup_dev

// ===== verilog/gate_sup_host.sv
// Added by the designer: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/1ps
module gate_sup_host (
   // Link to driver
   sup_link.host_mp                 lnk,
   // Reset
   input  wire logic                srst,
   // PWM command
   input  wire logic                pwmCmd,
   // Safe turn-off plateau to the driver configuration
   output logic [sup_pkg::PLAT_W-1:0] plateau,
   // AXI4-Lite write
   input  wire logic [sup_pkg::ADDR_W-1:0] awaddr,
   input  wire logic                awvalid,
   output logic                     awready,
   input  wire logic [31:0]         wdata,
   input  wire logic [3:0]          wstrb,
   input  wire logic                wvalid,
   output logic                     wready,
   output logic [1:0]               bresp,
   output logic                     bvalid,
   input  wire logic                bready,
   // AXI4-Lite read
   input  wire logic [sup_pkg::ADDR_W-1:0] araddr,
   input  wire logic                arvalid,
   output logic                     arready,
   output logic [31:0]              rdata,
   output logic [1:0]               rresp,
   output logic                     rvalid,
   input  wire logic                rready
);

   logic                         awHeld_q;
   logic                         wHeld_q;
   logic [sup_pkg::ADDR_W-1:0]   addr_q;
   logic [31:0]                  data_q;
   logic [3:0]                   strb_q;
   logic                         doWrite;
   logic [sup_pkg::CTRL_W-1:0]   ctrl_q;
   logic                         dioS1_q;
   logic                         dioS2_q;
   logic [31:0]                  rdMux;
   logic [1:0]                   rdResp;
   logic                         modeOk;
   logic                         inConfig;

   // ---------------------------------------------------------------
   // Write channel
   // ---------------------------------------------------------------
   assign awready = ~awHeld_q & ~bvalid;
   assign wready  = ~wHeld_q & ~bvalid;
   assign doWrite = awHeld_q & wHeld_q;

   always_ff @(posedge lnk.clk)
   begin
      if (srst)
      begin
         awHeld_q <= 1'b0;
         wHeld_q  <= 1'b0;
         addr_q   <= '0;
         data_q   <= '0;
         strb_q   <= 4'h0;
      end
      else
      begin
         if (awvalid && awready)
         begin
            awHeld_q <= 1'b1;
            addr_q   <= awaddr;
         end
         else if (doWrite)
         begin
            awHeld_q <= 1'b0;
         end
         if (wvalid && wready)
         begin
            wHeld_q <= 1'b1;
            data_q  <= wdata;
            strb_q  <= wstrb;
         end
         else if (doWrite)
         begin
            wHeld_q <= 1'b0;
         end
      end
   end

   always_ff @(posedge lnk.clk)
   begin
      if (srst)
      begin
         bvalid <= 1'b0;
         bresp  <= sup_pkg::RESP_OKAY;
      end
      else if (doWrite)
      begin
         bvalid <= 1'b1;
         bresp  <= (addr_q == sup_pkg::OFS_CTRL ||
                    addr_q == sup_pkg::OFS_CMD) ?
                   sup_pkg::RESP_OKAY : sup_pkg::RESP_SLVERR;
      end
      else if (bready)
      begin
         bvalid <= 1'b0;
      end
   end

   always_ff @(posedge lnk.clk)
   begin
      if (srst)
      begin
         ctrl_q <= sup_pkg::CTRL_RESET;
      end
      else if (doWrite && addr_q == sup_pkg::OFS_CTRL)
      begin
         if (strb_q[0])
         begin
            ctrl_q[7:0] <= data_q[7:0];
         end
         if (strb_q[1])
         begin
            ctrl_q[11:8] <= data_q[11:8];
         end
      end
   end

   always_ff @(posedge lnk.clk)
   begin
      if (srst)
      begin
         lnk.clrPrimary <= 1'b0;
      end
      else
      begin
         lnk.clrPrimary <= doWrite & (addr_q == sup_pkg::OFS_CMD)
                           & strb_q[0] & data_q[sup_pkg::CMD_PRIMARY_CLEAR_REQUEST];
      end
   end

   // ---------------------------------------------------------------
   // Read channel
   // ---------------------------------------------------------------
   assign arready = ~rvalid;

   always_comb
   begin
      rdMux  = 32'h0;
      rdResp = sup_pkg::RESP_OKAY;
      case (araddr)
         sup_pkg::OFS_CTRL: rdMux = {20'h0, ctrl_q};
         sup_pkg::OFS_CMD:  rdMux = 32'h0;
         sup_pkg::OFS_STAT: rdMux = {28'h0, dioS2_q, lnk.errNotify,
                                     lnk.mode};
         sup_pkg::OFS_PCNT: rdMux = {16'h0, lnk.priCount};
         sup_pkg::OFS_SCNT: rdMux = {16'h0, lnk.secCount};
         default:           rdResp = sup_pkg::RESP_SLVERR;
      endcase
   end

   always_ff @(posedge lnk.clk)
   begin
      if (srst)
      begin
         rvalid <= 1'b0;
         rdata  <= 32'h0;
         rresp  <= sup_pkg::RESP_OKAY;
      end
      else if (arvalid && arready)
      begin
         rvalid <= 1'b1;
         rdata  <= rdMux;
         rresp  <= rdResp;
      end
      else if (rready)
      begin
         rvalid <= 1'b0;
      end
   end

   // ---------------------------------------------------------------
   // Driver commands
   // ---------------------------------------------------------------
   // Unsafe requests are held back here rather than trusted to
   // software, since an overcurrent test with a raised plateau
   // would leave the gate at a partial voltage
   assign inConfig = (lnk.mode == sup_pkg::MODE_CONFIG);
   assign modeOk   = inConfig | (lnk.mode == sup_pkg::MODE_ACTIVE);

   always_ff @(posedge lnk.clk)
   begin
      if (srst)
      begin
         lnk.pwm     <= 1'b0;
         lnk.ocpTest <= 1'b0;
         lnk.supTest <= 1'b0;
         lnk.supSel  <= sup_pkg::SUP_SEC_UV;
         lnk.clkTest <= 1'b0;
         lnk.dioTest <= 1'b0;
      end
      else
      begin
         lnk.pwm     <= pwmCmd;
         lnk.ocpTest <= ctrl_q[sup_pkg::CTRL_OCP] & modeOk
                        & (plateau == 4'h0);
         lnk.supTest <= ctrl_q[sup_pkg::CTRL_SUP] & inConfig;
         lnk.supSel  <= sup_pkg::supsel_e'(ctrl_q[sup_pkg::CTRL_SEL +: 2]);
         lnk.clkTest <= ctrl_q[sup_pkg::CTRL_CLK];
         lnk.dioTest <= ctrl_q[sup_pkg::CTRL_DIO]
                        & ctrl_q[sup_pkg::CTRL_DIO_OUT];
      end
   end

   assign plateau = ctrl_q[sup_pkg::CTRL_PLAT +: sup_pkg::PLAT_W];

   // Pin level resynchronised before it reaches the status word
   always_ff @(posedge lnk.clk)
   begin
      if (srst)
      begin
         dioS1_q <= 1'b0;
         dioS2_q <= 1'b0;
      end
      else
      begin
         dioS1_q <= lnk.dioLevel;
         dioS2_q <= dioS1_q;
      end
   end

endmodule : gate_sup_host

// ===== dv/sup_monitor.sv
`timescale 1ns/1ps
module sup_monitor (
   // Clock and reset
   input wire logic                      clk,
   input wire logic                      srst,
   // Link signals
   input wire logic                      pwm,
   input wire logic                      supTest,
   input wire logic                      ocpTest,
   input wire logic                      dioTest,
   input wire logic                      clrPrimary,
   input wire sup_pkg::opmode_e          mode,
   input wire logic                      errNotify,
   input wire logic [sup_pkg::CNT_W-1:0] priCount,
   input wire logic [sup_pkg::CNT_W-1:0] secCount,
   input wire logic                      dioOut,
   input wire logic                      dioOe
);

   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);

   // ------------------------------------------------
   // Four-cycle pulse with the counter enabled
   // ------------------------------------------------
   sequence pulse4_s(en);
      !pwm ##1 (pwm && en)[*4] ##1 !pwm;
   endsequence

   pri_capture_a:
      assert property (pulse4_s(mode != sup_pkg::MODE_OTHER)
         |=> priCount == 16'h0004) else $error("primary count wrong");
   sec_capture_a:
      assert property (pulse4_s(mode == sup_pkg::MODE_ACTIVE)
         |=> secCount == 16'h0004) else $error("secondary count wrong");
   pri_change_a:
      assert property ($changed(priCount) |-> $past(clrPrimary)
         || ($past(pwm, 2) && !$past(pwm)))
         else $error("primary count moved off a fall");
   sec_change_a:
      assert property ($changed(secCount) |-> $past(pwm, 2) && !$past(pwm))
         else $error("secondary count moved off a fall");
   pri_clear_a:
      assert property (clrPrimary && !$fell(pwm) |=> priCount == 16'h0000)
         else $error("primary count not cleared");
   dio_loop_a:
      assert property (dioOe |-> $past(dioTest) && dioOut == $past(pwm))
         else $error("pin does not follow pwm");
   oc_error_a:
      assert property (mode == sup_pkg::MODE_ACTIVE && ocpTest
         && $past(ocpTest) && $past(mode) != sup_pkg::MODE_ACTIVE
         |-> ##[0:3] errNotify) else $error("no overcurrent error");
   sup_err_a:
      assert property (supTest ##1 supTest |-> ##[0:2] errNotify)
         else $error("no supply error");

endmodule : sup_monitor

// ===== dv/test_gate_supervision_tests.sv
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin n_tests++; if ((got) !== (ex)) begin \
   n_fail++; $display("mismatch %s expected %h seen %h", nm, ex, got); \
   end end
module test_gate_driver_supervision_tests;

   // ------------------------------------------------
   // Stimulus and observation
   // ------------------------------------------------
   logic             clk     = 1'b0;
   logic             srst    = 1'b1;
   logic             pwmCmd  = 1'b0;
   sup_pkg::opmode_e opMode  = sup_pkg::MODE_OTHER;
   logic [7:0]       awaddr  = 8'h00;
   logic [7:0]       araddr  = 8'h00;
   logic [31:0]      wdata   = 32'h00000000;
   logic             awvalid = 1'b0;
   logic             wvalid  = 1'b0;
   logic             arvalid = 1'b0;
   logic             bready  = 1'b1;
   logic             rready  = 1'b1;
   logic             awready, wready, bvalid, arready, rvalid;
   logic [1:0]       bresp, rresp, ocForce;
   logic [31:0]      rdata;
   logic [3:0]       plateau, supForce;
   logic             ocError, gateDrive, secPwm, gHi, sHi, dHi;
   int               n_fail  = 0;
   int               n_tests = 0;
   int               nOc     = 0;

   always #25 clk = ~clk;
   always @(posedge clk) if (ocError === 1'b1) nOc++;

   sup_link lnk (.clk(clk));
   gate_sup_dev i_gate_sup_dev (.lnk(lnk), .srst(srst), .opMode(opMode),
      .ocForce(ocForce), .supForce(supForce), .ocError(ocError),
      .gateDrive(gateDrive), .secPwm(secPwm));
   gate_sup_host i_gate_sup_host (.lnk(lnk), .srst(srst), .pwmCmd(pwmCmd),
      .plateau(plateau), .awaddr(awaddr), .awvalid(awvalid),
      .awready(awready), .wdata(wdata), .wstrb(4'hF), .wvalid(wvalid),
      .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
      .araddr(araddr), .arvalid(arvalid), .arready(arready),
      .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));
   sup_monitor i_sup_monitor (.clk(clk), .srst(srst), .pwm(lnk.pwm),
      .supTest(lnk.supTest), .ocpTest(lnk.ocpTest), .dioTest(lnk.dioTest),
      .clrPrimary(lnk.clrPrimary), .mode(lnk.mode),
      .errNotify(lnk.errNotify), .priCount(lnk.priCount),
      .secCount(lnk.secCount), .dioOut(lnk.dioOut), .dioOe(lnk.dioOe));

   // ------------------------------------------------
   // Bus and pulse tasks
   // ------------------------------------------------
   task automatic wr(input logic [7:0] a, input logic [31:0] d,
                     input logic [1:0] er);
      awaddr  <= a;
      wdata   <= d;
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      do
      begin
         @(posedge clk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end
      while ((awvalid && !awready) || (wvalid && !wready));
      do @(posedge clk); while (bvalid !== 1'b1);
      `CHK("bresp", er, bresp)
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [31:0] ex,
                     input logic [1:0] er);
      araddr  <= a;
      arvalid <= 1'b1;
      do @(posedge clk); while (arready !== 1'b1);
      arvalid <= 1'b0;
      do @(posedge clk); while (rvalid !== 1'b1);
      `CHK("rdata", ex, rdata)
      `CHK("rresp", er, rresp)
   endtask : rd

   // Samples the paths mid-pulse, once the pipeline has settled
   task automatic pulse(input int n);
      pwmCmd <= 1'b1;
      repeat (3) @(posedge clk);
      gHi = gateDrive;
      sHi = secPwm;
      dHi = lnk.dioLevel;
      repeat (n - 3) @(posedge clk);
      pwmCmd <= 1'b0;
      repeat (4) @(posedge clk);
   endtask : pulse

   task automatic setMode(input sup_pkg::opmode_e m);
      opMode <= m;
      repeat (4) @(posedge clk);
   endtask : setMode

   task automatic complete_run;
      $display("comparisons %0d mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : complete_run

   initial
   begin
      repeat (3) @(posedge clk);
      srst <= 1'b0;
      @(posedge clk);
      rd(sup_pkg::OFS_CTRL, 32'h0, sup_pkg::RESP_OKAY);
      rd(sup_pkg::OFS_SCNT, 32'h0, sup_pkg::RESP_OKAY);
      rd(8'h14, 32'h0, sup_pkg::RESP_SLVERR);
      wr(8'h14, 32'h1, sup_pkg::RESP_SLVERR);
      $display("test reset done");
      setMode(sup_pkg::MODE_CONFIG);
      pulse(4);
      rd(sup_pkg::OFS_PCNT, 32'h4, sup_pkg::RESP_OKAY);
      rd(sup_pkg::OFS_SCNT, 32'h0, sup_pkg::RESP_OKAY);
      wr(sup_pkg::OFS_CMD, 32'h1, sup_pkg::RESP_OKAY);
      rd(sup_pkg::OFS_PCNT, 32'h0, sup_pkg::RESP_OKAY);
      pulse(7);
      pulse(4);
      rd(sup_pkg::OFS_PCNT, 32'h4, sup_pkg::RESP_OKAY);
      $display("test primary done");
      setMode(sup_pkg::MODE_ACTIVE);
      pulse(4);
      `CHK("gate", 1'b1, gHi)
      `CHK("secpwm", 1'b1, sHi)
      rd(sup_pkg::OFS_SCNT, 32'h4, sup_pkg::RESP_OKAY);
      wr(sup_pkg::OFS_CMD, 32'h1, sup_pkg::RESP_OKAY);
      rd(sup_pkg::OFS_SCNT, 32'h4, sup_pkg::RESP_OKAY);
      wr(sup_pkg::OFS_CTRL, 32'h10, sup_pkg::RESP_OKAY);
      pulse(4);
      `CHK("gate", 1'b0, gHi)
      wr(sup_pkg::OFS_CTRL, 32'h0, sup_pkg::RESP_OKAY);
      setMode(sup_pkg::MODE_CONFIG);
      pulse(5);
      rd(sup_pkg::OFS_SCNT, 32'h4, sup_pkg::RESP_OKAY);
      rd(sup_pkg::OFS_PCNT, 32'h5, sup_pkg::RESP_OKAY);
      $display("test secondary done");
      wr(sup_pkg::OFS_CTRL, 32'h60, sup_pkg::RESP_OKAY);
      pulse(4);
      `CHK("pin", 1'b1, dHi)
      `CHK("secpwm", 1'b0, sHi)
      wr(sup_pkg::OFS_CTRL, 32'h20, sup_pkg::RESP_OKAY);
      pulse(4);
      `CHK("pin", 1'b0, dHi)
      wr(sup_pkg::OFS_CTRL, 32'h0, sup_pkg::RESP_OKAY);
      $display("test loopback done");
      for (int s = 0; s < 4; s++)
      begin
         wr(sup_pkg::OFS_CTRL, 32'h2 | (s << 2), sup_pkg::RESP_OKAY);
         repeat (3) @(posedge clk);
         `CHK("supforce", 4'h1 << s, supForce)
         rd(sup_pkg::OFS_STAT, 32'h5, sup_pkg::RESP_OKAY);
         wr(sup_pkg::OFS_CTRL, 32'h0, sup_pkg::RESP_OKAY);
      end
      // The error drops one cycle after the forced monitor lets go
      repeat (3) @(posedge clk);
      rd(sup_pkg::OFS_STAT, 32'h1, sup_pkg::RESP_OKAY);
      setMode(sup_pkg::MODE_ACTIVE);
      wr(sup_pkg::OFS_CTRL, 32'h2, sup_pkg::RESP_OKAY);
      repeat (3) @(posedge clk);
      `CHK("supforce", 4'h0, supForce)
      rd(sup_pkg::OFS_STAT, 32'h2, sup_pkg::RESP_OKAY);
      wr(sup_pkg::OFS_CTRL, 32'h0, sup_pkg::RESP_OKAY);
      $display("test supply done");
      setMode(sup_pkg::MODE_CONFIG);
      wr(sup_pkg::OFS_CTRL, 32'h101, sup_pkg::RESP_OKAY);
      repeat (3) @(posedge clk);
      `CHK("plateau", 4'h1, plateau)
      `CHK("ocforce", 2'b00, ocForce)
      wr(sup_pkg::OFS_CTRL, 32'h1, sup_pkg::RESP_OKAY);
      repeat (3) @(posedge clk);
      `CHK("ocforce", 2'b11, ocForce)
      `CHK("ocerror", 0, nOc)
      setMode(sup_pkg::MODE_ACTIVE);
      `CHK("ocerror", 1, nOc)
      rd(sup_pkg::OFS_STAT, 32'h6, sup_pkg::RESP_OKAY);
      pulse(4);
      `CHK("gate", 1'b0, gHi)
      wr(sup_pkg::OFS_CTRL, 32'h0, sup_pkg::RESP_OKAY);
      $display("test overcurrent done");
      pulse(65540);
      rd(sup_pkg::OFS_PCNT, 32'hFFFF, sup_pkg::RESP_OKAY);
      rd(sup_pkg::OFS_SCNT, 32'hFFFF, sup_pkg::RESP_OKAY);
      srst <= 1'b1;
      repeat (3) @(posedge clk);
      srst <= 1'b0;
      @(posedge clk);
      rd(sup_pkg::OFS_SCNT, 32'h0, sup_pkg::RESP_OKAY);
      $display("test saturation done");
      complete_run();
   end

   // Whole run needs about 66000 cycles
   initial
   begin
      repeat (75000) @(posedge clk);
      n_fail++;
      complete_run();
   end

endmodule : test_gate_driver_supervision_tests
